// ==== fscr_props.sv ====
/* Assertions on the fault and clipper register slice.
   Assumes one clock and a bind into fscr_top. */
`timescale 1ns/1ps
`default_nettype none
module fscr_props (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_speaker_shutdown_n,
  input wire logic i_shutdown_ctrl_n,
  input wire logic i_clk_fault_det,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [1:0] o_overcurrent_trip_scale,
  input wire logic [13:0] o_clip_threshold,
  input wire logic o_clock_fault_flag,
  input wire logic o_overcurrent_flag,
  input wire logic o_output_dc_fault_flag,
  input wire logic o_overtemp_flag,
  input wire logic o_run
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  wire quiet = i_speaker_shutdown_n && i_shutdown_ctrl_n;
  sequence calm6; quiet[*6]; endsequence
  scale_out_a: assert property (i_wr_en && i_addr == 8'h08 |->
    ##2 o_overcurrent_trip_scale == $past(i_wdata[5:4], 2)) else $error("scale mismatch");
  clip_mid_a: assert property (i_wr_en && i_addr == 8'h10 |->
    ##2 o_clip_threshold[13:6] == $past(i_wdata, 2)) else $error("clip mid mismatch");
  clip_low_a: assert property (i_wr_en && i_addr == 8'h11 |->
    ##2 o_clip_threshold[5:0] == $past(i_wdata[7:2], 2)) else $error("clip low mismatch");
  rsv_zero_a: assert property (o_rvalid && $past(i_addr) == 8'h08 |->
    o_rdata[7:6] == 2'b00) else $error("reserved bits set");
  clk_clear_a: assert property ((!i_clk_fault_det)[*8] |-> !o_clock_fault_flag)
    else $error("clock flag stuck");
  oc_hold_a: assert property (calm6 ##0 o_overcurrent_flag |=> o_overcurrent_flag)
    else $error("overcurrent flag lost");
  dc_hold_a: assert property (calm6 ##0 o_output_dc_fault_flag |=> o_output_dc_fault_flag)
    else $error("dc flag lost");
  ot_hold_a: assert property (calm6 ##0 o_overtemp_flag |=> o_overtemp_flag)
    else $error("overtemp flag lost");
  oc_halt_a: assert property (o_overcurrent_flag[*2] |-> !o_run)
    else $error("run during fault");
  sd_stop_a: assert property ((!i_shutdown_ctrl_n)[*3] |-> !o_run)
    else $error("run during shutdown");
endmodule // fscr_props
bind fscr_top fscr_props chk_u (.*);
`default_nettype wire

// ==== fscr_regs.vh ====
/*
  Register offsets, field positions and reset values of the fault and clipper register slice.
  Assumes the control-port decoder presents byte-wide register accesses.
*/
`ifndef FSCR_REGS_VH
`define FSCR_REGS_VH
`define FSCR_ADDR_FAULT 8'h08
`define FSCR_ADDR_RSV_LO 8'h09
`define FSCR_ADDR_RSV_HI 8'h0F
`define FSCR_ADDR_CLIP_MID 8'h10
`define FSCR_ADDR_CLIP_LOW 8'h11
`define FSCR_BIT_OTE 0
`define FSCR_BIT_DCE 1
`define FSCR_BIT_OCE 2
`define FSCR_BIT_CLOCK_FAULT_FLAG 3
`define FSCR_SCALE_LSB 4
`define FSCR_SCALE_MSB 5
`define FSCR_SCALE_RST 2'h0
`define FSCR_SCALE_100 2'h0
`define FSCR_SCALE_75 2'h1
`define FSCR_SCALE_50 2'h2
`define FSCR_SCALE_25 2'h3
`define FSCR_CLIP_MID_RST 8'h01
`define FSCR_CLIP_LOW_RST 8'h04
`define FSCR_SYNC_DEPTH 3
`endif

// ==== fscr_sync.v ====
/*
  Three-stage synchroniser for one asynchronous level; output changes once stages two and three agree.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fscr_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_d,
  output reg o_q
);
  reg [2:0] st_r;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= {3{RST_VAL}};
      o_q <= RST_VAL;
    end else begin
      st_r <= {st_r[1:0], i_d};
      if (st_r[1] == st_r[2]) begin
        o_q <= st_r[2];
      end
    end
  end
endmodule // fscr_sync
`default_nettype wire

// ==== fscr_top.v ====
/*
  Fault configuration, error status and clipper threshold registers of the amplifier control port.
  Assumes a byte-wide register access port from the control-port decoder and raw detector levels.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fscr_regs.vh"
module fscr_top (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_speaker_shutdown_n,
  input wire i_shutdown_ctrl_n,
  input wire i_clk_fault_det,
  input wire i_overcurrent_det,
  input wire i_dc_fault_det,
  input wire i_overtemp_det,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  output reg [1:0] o_overcurrent_trip_scale,
  output reg [13:0] o_clip_threshold,
  output reg o_clock_fault_flag,
  output reg o_overcurrent_flag,
  output reg o_output_dc_fault_flag,
  output reg o_overtemp_flag,
  output reg o_run
);
  wire sd_pin_s;
  wire clk_det_s;
  wire oc_det_s;
  wire dc_det_s;
  wire ot_det_s;
  wire wr_fault;
  wire wr_clip_mid;
  wire wr_clip_low;
  wire sd_active;
  wire sd_toggle;
  wire [7:0] fault_rd;
  reg [1:0] scale_r;
  reg [7:0] clip_mid_r;
  reg [7:0] clip_low_r;
  reg clock_fault_flag_r;
  reg oce_r;
  reg dce_r;
  reg ote_r;
  reg oce_nxt;
  reg dce_nxt;
  reg ote_nxt;
  reg sd_prev_r;
  reg run_nxt;
  reg [7:0] rdata_nxt;

  fscr_sync #(
    .RST_VAL(1'h0)
  ) u_sync_sd (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_speaker_shutdown_n),
    .o_q(sd_pin_s)
  );

  fscr_sync #(
    .RST_VAL(1'h0)
  ) u_sync_clk (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_clk_fault_det),
    .o_q(clk_det_s)
  );

  fscr_sync #(
    .RST_VAL(1'h0)
  ) u_sync_oc (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_overcurrent_det),
    .o_q(oc_det_s)
  );

  fscr_sync #(
    .RST_VAL(1'h0)
  ) u_sync_dc (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_dc_fault_det),
    .o_q(dc_det_s)
  );

  fscr_sync #(
    .RST_VAL(1'h0)
  ) u_sync_ot (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_d(i_overtemp_det),
    .o_q(ot_det_s)
  );

  assign sd_active = ~sd_pin_s | ~i_shutdown_ctrl_n;
  assign sd_toggle = sd_active & ~sd_prev_r;

  assign fault_rd = {2'h0, scale_r, clock_fault_flag_r, oce_r, dce_r, ote_r};

  assign wr_fault = i_wr_en & (i_addr == `FSCR_ADDR_FAULT);
  assign wr_clip_mid = i_wr_en & (i_addr == `FSCR_ADDR_CLIP_MID);
  assign wr_clip_low = i_wr_en & (i_addr == `FSCR_ADDR_CLIP_LOW);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scale_r <= `FSCR_SCALE_RST;
    end else if (wr_fault) begin
      scale_r <= i_wdata[`FSCR_SCALE_MSB:`FSCR_SCALE_LSB];
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clip_mid_r <= `FSCR_CLIP_MID_RST;
    end else if (wr_clip_mid) begin
      clip_mid_r <= i_wdata;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clip_low_r <= `FSCR_CLIP_LOW_RST;
    end else if (wr_clip_low) begin
      clip_low_r <= i_wdata;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sd_prev_r <= 1'h1;
    end else begin
      sd_prev_r <= sd_active;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clock_fault_flag_r <= 1'h0;
    end else begin
      clock_fault_flag_r <= clk_det_s;
    end
  end

  always @* begin
    oce_nxt = oce_r & ~sd_toggle;
    if (oc_det_s) begin
      oce_nxt = 1'h1;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oce_r <= 1'h0;
    end else begin
      oce_r <= oce_nxt;
    end
  end

  always @* begin
    dce_nxt = dce_r & ~sd_toggle;
    if (dc_det_s) begin
      dce_nxt = 1'h1;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dce_r <= 1'h0;
    end else begin
      dce_r <= dce_nxt;
    end
  end

  always @* begin
    ote_nxt = ote_r & ~sd_toggle;
    if (ot_det_s) begin
      ote_nxt = 1'h1;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ote_r <= 1'h0;
    end else begin
      ote_r <= ote_nxt;
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    case (i_addr)
      `FSCR_ADDR_FAULT: rdata_nxt = fault_rd;
      `FSCR_ADDR_CLIP_MID: rdata_nxt = clip_mid_r;
      `FSCR_ADDR_CLIP_LOW: rdata_nxt = clip_low_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'h0;
    end else begin
      o_rvalid <= i_rd_en;
      if (i_rd_en) begin
        o_rdata <= rdata_nxt;
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_overcurrent_trip_scale <= `FSCR_SCALE_RST;
    end else begin
      o_overcurrent_trip_scale <= scale_r;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_clip_threshold <= 14'h0000;
    end else begin
      o_clip_threshold <= {clip_mid_r, clip_low_r[7:2]};
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_clock_fault_flag <= 1'h0;
      o_overcurrent_flag <= 1'h0;
      o_output_dc_fault_flag <= 1'h0;
      o_overtemp_flag <= 1'h0;
    end else begin
      o_clock_fault_flag <= clock_fault_flag_r;
      o_overcurrent_flag <= oce_r;
      o_output_dc_fault_flag <= dce_r;
      o_overtemp_flag <= ote_r;
    end
  end

  always @* begin
    run_nxt = ~sd_active & ~clock_fault_flag_r & ~oce_r & ~dce_r & ~ote_r;
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_run <= 1'h0;
    end else begin
      o_run <= run_nxt;
    end
  end
endmodule // fscr_top
`default_nettype wire

// ==== fscr_top_tb.sv ====
/* Testbench of the fault and clipper register slice.
   Assumes fscr_top with one-cycle read and write strobes. */
`timescale 1ns/1ps
`default_nettype none
`include "fscr_regs.vh"
module fscr_top_tb;
  logic i_clk = 0, i_arst_n = 0, i_wr_en = 0, i_rd_en = 0;
  logic i_speaker_shutdown_n = 1, i_shutdown_ctrl_n = 1, i_clk_fault_det = 0;
  logic i_overcurrent_det = 0, i_dc_fault_det = 0, i_overtemp_det = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
  logic [1:0] o_overcurrent_trip_scale;
  logic [13:0] o_clip_threshold;
  logic o_rvalid, o_clock_fault_flag, o_overcurrent_flag, o_output_dc_fault_flag;
  logic o_overtemp_flag, o_run;
  int errors = 0, checks_done = 0;
  fscr_top dut_u (.*);
  always #4 i_clk = ~i_clk;
  task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    cmp("rsv_addr", 0, a >= `FSCR_ADDR_RSV_LO && a <= `FSCR_ADDR_RSV_HI);
    @(posedge i_clk) {i_wr_en, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk) i_wr_en <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    cmp("rsv_addr", 0, a >= `FSCR_ADDR_RSV_LO && a <= `FSCR_ADDR_RSV_HI);
    @(posedge i_clk) {i_rd_en, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd_en <= 0;
    #1;
    cmp("rvalid", 1, o_rvalid);
    cmp("rdata", e, o_rdata);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1;
    rd(8'h08, 8'h00);
    rd(8'h10, 8'h01);
    rd(8'h11, 8'h04);
    $display("reset test done");
    for (logic [2:0] c = 0; c < 4; c++) begin
      wr(8'h08, {2'b00, c[1:0], 4'hF});
      rd(8'h08, {2'b00, c[1:0], 4'h0});
      cmp("scale", c[1:0], o_overcurrent_trip_scale);
    end
    wr(8'h10, 8'hAB);
    wr(8'h11, 8'hFC);
    rd(8'h10, 8'hAB);
    cmp("clip", {8'hAB, 6'h3F}, o_clip_threshold);
    $display("register test done");
    @(posedge i_clk) i_overcurrent_det <= 1;
    wt(8);
    @(posedge i_clk) i_overcurrent_det <= 0;
    wt(8);
    cmp("run", 0, o_run);
    rd(8'h08, 8'h34);
    @(posedge i_clk) i_shutdown_ctrl_n <= 0;
    wt(8);
    cmp("oc", 0, o_overcurrent_flag);
    @(posedge i_clk) {i_shutdown_ctrl_n, i_clk_fault_det} <= 2'b11;
    wt(8);
    cmp("clkf", 1, o_clock_fault_flag);
    @(posedge i_clk) i_clk_fault_det <= 0;
    wt(8);
    cmp("clkr", 2'b01, {o_clock_fault_flag, o_run});
    @(posedge i_clk) {i_dc_fault_det, i_overtemp_det} <= 2'b11;
    wt(8);
    @(posedge i_clk) {i_dc_fault_det, i_overtemp_det} <= 2'b00;
    wt(8);
    cmp("dcot", 2'b11, {o_output_dc_fault_flag, o_overtemp_flag});
    @(posedge i_clk) i_speaker_shutdown_n <= 0;
    wt(8);
    cmp("dcot", 2'b00, {o_output_dc_fault_flag, o_overtemp_flag});
    $display("fault test done");
    wrap_up();
  end
endmodule // fscr_top_tb
`default_nettype wire
